/* logic/pra_pkg.sv */
// Package of constants and types for the reset and alarm pin block.
// Notes on behaviour
// - Any external reset pin resets all four channels.
// - External reset returns every register to default.
// - Clock outputs tristated while reset is held.
// - No clock output until host writes configuration.
// - Pin is interrupt only when its enable is set.
// - Interrupt is maskable, polarity bit selects level.
// - Alarm shows loss as one, polarity bit electrical.
// - Pin tristates when no function is selected.
package pra_pkg;

  // Number of channels and bus widths.
  localparam int NCH = 4;
  localparam int AW  = 8;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PIN  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_LIVE = 8'h10;

  // Field positions in the control register.
  localparam int CTRL_SRST = 0;
  localparam int CTRL_OEN  = 4;

  // Field positions in the pin configuration register.
  localparam int PIN_IRQ_EN = 0;
  localparam int PIN_ALM_EN = 4;
  localparam int PIN_IRQPOL = 8;
  localparam int PIN_CKBPOL = 12;

  // Field positions in the live status register.
  localparam int LIVE_LOS = 0;
  localparam int LIVE_CKO = 4;
  localparam int LIVE_PH  = 8;

  // Values after reset.
  localparam logic [3:0] RST_OEN  = 4'h0;
  localparam logic [3:0] RST_IEN  = 4'h0;
  localparam logic [3:0] RST_AEN  = 4'h0;
  localparam logic [3:0] RST_IPOL = 4'hf;
  localparam logic [3:0] RST_CPOL = 4'hf;
  localparam logic [3:0] RST_MASK = 4'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Software reset quiet time, in ns, and its cycle count at 200 MHz.
  localparam longint SRST_NS  = 10000000;
  localparam longint CLK_NS   = 5;
  localparam int     SRST_CW  = 21;
  localparam logic [SRST_CW-1:0] SRST_CYC = SRST_CW'((SRST_NS + CLK_NS - 1) / CLK_NS);

  // Reset synchroniser depth.
  localparam int SYNC_N = 2;

  // Device phase, Gray coded along the usual path.
  typedef enum logic [1:0] {
    PH_RESET = 2'h0,
    PH_UNCFG = 2'h1,
    PH_RUN   = 2'h3,
    PH_SOFT  = 2'h2
  } pra_phase_e;

endpackage

/* logic/pra_rst_sync.sv */
// Release synchroniser for the combined external reset pins.
`timescale 1ns/100ps
`default_nettype none
module pra_rst_sync
  import pra_pkg::*;
(
  // Clock and bus reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Raw active low reset request and its synchronised release.
  input  wire logic req_n,
  output logic      rel_n
);
  import pra_pkg::*;

  // All state of the synchroniser.
  typedef struct packed {
    logic [SYNC_N-1:0] sr;
  } pra_sync_s;

  pra_sync_s s_q;
  pra_sync_s s_d;

  // Shift ones in while released; the chain clears while requested.
  always_comb begin
    s_d = s_q;
    if (!req_n) begin
      s_d.sr = '0;
    end else begin
      s_d.sr = {s_q.sr[SYNC_N-2:0], 1'b1};
    end
  end

  // Register the state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Assertion follows the pin at once, release only via the last stage.
  assign rel_n = req_n & s_q.sr[SYNC_N-1];

endmodule
`default_nettype wire

/* logic/pra_top.sv */
// Reset pins, clock output enables and alarm pins of four clock channels.
`timescale 1ns/100ps
`default_nettype none
module pra_top
  import pra_pkg::*;
#(
  parameter logic [pra_pkg::SRST_CW-1:0] SOFT_RST_CYC = pra_pkg::SRST_CYC
)
(
  // Clock and bus reset.
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // External reset pins, one per channel.
  input  wire logic            ext_reset_n_ch_a,
  input  wire logic            ext_reset_n_ch_b,
  input  wire logic            ext_reset_n_ch_c,
  input  wire logic            ext_reset_n_ch_d,
  // Loss of signal on each reference input.
  input  wire logic [3:0]      loss_of_signal,
  // Clock output drive enables.
  output logic [3:0]           clk_out_oe,
  // Interrupt and alarm pins.
  output logic [3:0]           alarm_pin_o,
  output logic [3:0]           alarm_pin_oe,
  // Summary interrupt.
  output logic                 irq,
  // AXI4-Lite write address.
  input  wire logic [pra_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [pra_pkg::AW-1:0] s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  import pra_pkg::*;

  // All state of the block.
  typedef struct packed {
    pra_phase_e         phase;    // Device phase.
    logic [SRST_CW-1:0] cnt;      // Software reset countdown.
    logic [3:0]         oen;      // Clock output enables.
    logic [3:0]         ien;      // Interrupt function select.
    logic [3:0]         aen;      // Raw alarm function select.
    logic [3:0]         ipol;     // Interrupt active level.
    logic [3:0]         cpol;     // Clock fault active level.
    logic [3:0]         stat;     // Sticky loss events.
    logic [3:0]         mask;     // Interrupt enables.
    logic [3:0]         los_p;    // Loss level one cycle ago.
    logic [3:0]         pin_o;    // Pin levels.
    logic [3:0]         pin_oe;   // Pin drive enables.
    logic [3:0]         cko;      // Clock output enables.
    logic               aw_have;  // Write address held.
    logic [AW-1:0]      awaddr;   // Held write address.
    logic               w_have;   // Write data held.
    logic [31:0]        wdata;    // Held write data.
    logic [3:0]         wstrb;    // Held byte strobes.
    logic               bvalid;   // Write response pending.
    logic [1:0]         bresp;    // Write response code.
    logic               rvalid;   // Read data pending.
    logic [31:0]        rdata;    // Read data.
    logic [1:0]         rresp;    // Read response code.
  } pra_state_s;

  pra_state_s s_q;
  pra_state_s s_d;

  // Combined external reset request and its synchronised release.
  logic ext_req_n;
  logic ext_rel_n;

  // Any of the four pins resets the whole device.
  assign ext_req_n = ext_reset_n_ch_a & ext_reset_n_ch_b
                   & ext_reset_n_ch_c & ext_reset_n_ch_d;

  pra_rst_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req_n   (ext_req_n),
    .rel_n   (ext_rel_n)
  );

  // Merge write data into an old word under byte strobes.
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Next state logic.
  always_comb begin
    logic [31:0] ctrl_v;
    logic [31:0] pin_v;
    logic [31:0] mw;
    logic [3:0]  rise;
    logic [3:0]  w1c;
    logic [3:0]  act;
    logic        do_wr;
    ctrl_v = '0;
    pin_v  = '0;
    mw     = '0;
    rise   = '0;
    w1c    = '0;
    act    = '0;
    do_wr  = 1'b0;
    s_d    = s_q;

    // Current register images for read back and merging.
    ctrl_v[CTRL_SRST]    = (s_q.phase == PH_SOFT);
    ctrl_v[CTRL_OEN +: 4] = s_q.oen;
    pin_v[PIN_IRQ_EN +: 4] = s_q.ien;
    pin_v[PIN_ALM_EN +: 4] = s_q.aen;
    pin_v[PIN_IRQPOL +: 4] = s_q.ipol;
    pin_v[PIN_CKBPOL +: 4] = s_q.cpol;

    // Capture write address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end

    // Retire the write response.
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Perform a held write once both halves are in.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      do_wr       = 1'b1;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OK;
    end

    // Loss events set sticky bits on the rising edge.
    rise      = loss_of_signal & ~s_q.los_p;
    s_d.los_p = loss_of_signal;

    // Address decode of the write.
    if (do_wr) begin
      if (s_q.awaddr == OFF_CTRL) begin
        mw = merge(ctrl_v, s_q.wdata, s_q.wstrb);
        // Writes are ignored during the software reset quiet time.
        if (s_q.phase != PH_SOFT) begin
          s_d.oen = mw[CTRL_OEN +: 4];
          if (mw[CTRL_SRST]) begin
            s_d.phase = PH_SOFT;
            s_d.cnt   = SOFT_RST_CYC;
          end
        end
      end else if (s_q.awaddr == OFF_PIN) begin
        mw = merge(pin_v, s_q.wdata, s_q.wstrb);
        if (s_q.phase != PH_SOFT) begin
          s_d.ien  = mw[PIN_IRQ_EN +: 4];
          s_d.aen  = mw[PIN_ALM_EN +: 4];
          s_d.ipol = mw[PIN_IRQPOL +: 4];
          s_d.cpol = mw[PIN_CKBPOL +: 4];
        end
      end else if (s_q.awaddr == OFF_STAT) begin
        // Write one to clear; only byte lane zero matters.
        if (s_q.wstrb[0]) begin
          w1c = s_q.wdata[3:0];
        end
      end else if (s_q.awaddr == OFF_MASK) begin
        mw = merge({28'h0, s_q.mask}, s_q.wdata, s_q.wstrb);
        if (s_q.phase != PH_SOFT) begin
          s_d.mask = mw[3:0];
        end
      end else if (s_q.awaddr == OFF_LIVE) begin
        // Read only register; writes have no effect.
        s_d.bresp = RESP_OK;
      end else begin
        // Unmapped address.
        s_d.bresp = RESP_ERR;
      end
    end

    // A new event wins over a clear in the same cycle.
    s_d.stat = (s_q.stat & ~w1c) | rise;

    // Read channel.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OK;
      if (s_axi_araddr == OFF_CTRL) begin
        s_d.rdata = ctrl_v;
      end else if (s_axi_araddr == OFF_PIN) begin
        s_d.rdata = pin_v;
      end else if (s_axi_araddr == OFF_STAT) begin
        s_d.rdata = {28'h0, s_q.stat};
      end else if (s_axi_araddr == OFF_MASK) begin
        s_d.rdata = {28'h0, s_q.mask};
      end else if (s_axi_araddr == OFF_LIVE) begin
        s_d.rdata = '0;
        s_d.rdata[LIVE_LOS +: 4] = loss_of_signal;
        s_d.rdata[LIVE_CKO +: 4] = s_q.cko;
        s_d.rdata[LIVE_PH +: 2]  = s_q.phase;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = RESP_ERR;
      end
    end

    // Phase sequence.
    case (s_q.phase)
      PH_RESET: begin
        s_d.phase = PH_UNCFG;
      end
      PH_UNCFG: begin
        // clocks only once software enables them.
        if (s_d.phase != PH_SOFT && s_d.oen != 4'h0) begin
          s_d.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        if (s_d.phase != PH_SOFT && s_d.oen == 4'h0) begin
          s_d.phase = PH_UNCFG;
        end
      end
      PH_SOFT: begin
        // quiet time with the configuration held at defaults.
        s_d.oen  = RST_OEN;
        s_d.ien  = RST_IEN;
        s_d.aen  = RST_AEN;
        s_d.ipol = RST_IPOL;
        s_d.cpol = RST_CPOL;
        s_d.mask = RST_MASK;
        s_d.stat = '0;
        if (s_q.cnt <= SRST_CW'(1)) begin
          s_d.cnt   = '0;
          s_d.phase = PH_RESET;
        end else begin
          s_d.cnt = s_q.cnt - SRST_CW'(1);
        end
      end
      default: begin
        s_d.phase = PH_RESET;
      end
    endcase

    // clock outputs drive only in the running phase.
    s_d.cko = (s_d.phase == PH_RUN) ? s_d.oen : 4'h0;

    // Pin function per channel.
    act = s_d.stat & s_d.mask;
    for (int c = 0; c < NCH; c++) begin
      if (s_d.ien[c]) begin
        // masked event at the chosen level.
        s_d.pin_oe[c] = 1'b1;
        s_d.pin_o[c]  = ~(act[c] ^ s_d.ipol[c]);
      end else if (s_d.aen[c]) begin
        // loss reads as one, polarity picks the level.
        s_d.pin_oe[c] = 1'b1;
        s_d.pin_o[c]  = ~(loss_of_signal[c] ^ s_d.cpol[c]);
      end else begin
        s_d.pin_oe[c] = 1'b0;
        s_d.pin_o[c]  = 1'b0;
      end
    end
  end

  // Register the state; any reset pin returns everything to its default.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ext_rel_n) begin
      s_q       <= '0;
      s_q.phase <= PH_RESET;
      s_q.oen   <= RST_OEN;
      s_q.ien   <= RST_IEN;
      s_q.aen   <= RST_AEN;
      s_q.ipol  <= RST_IPOL;
      s_q.cpol  <= RST_CPOL;
      s_q.mask  <= RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // clock outputs released while the reset pin is low.
  assign clk_out_oe = ext_req_n ? s_q.cko : 4'h0;

  // Pins come straight from flip-flops.
  assign alarm_pin_o  = s_q.pin_o;
  assign alarm_pin_oe = s_q.pin_oe;

  // Summary interrupt while any unmasked event is held.
  assign irq = |(s_q.stat & s_q.mask);

  // Bus handshakes.
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

endmodule
`default_nettype wire

/* tb/pra_chk.sv */
// Port checker for reset, clock enable, alarm and bus timing.
`timescale 1ns/100ps
`default_nettype none
module pra_chk
  import pra_pkg::*;
#(
  parameter logic [SRST_CW-1:0] SOFT_RST_CYC = SRST_CYC
)
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Reset pins and loss inputs.
  input wire logic        ext_reset_n_ch_a,
  input wire logic        ext_reset_n_ch_b,
  input wire logic        ext_reset_n_ch_c,
  input wire logic        ext_reset_n_ch_d,
  input wire logic [3:0]  loss_of_signal,
  // Pin outputs.
  input wire logic [3:0]  clk_out_oe,
  input wire logic [3:0]  alarm_pin_oe,
  input wire logic        irq,
  // Bus handshakes.
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // High while every reset pin is released.
  wire logic all_rel = &{ext_reset_n_ch_a, ext_reset_n_ch_b, ext_reset_n_ch_c, ext_reset_n_ch_d};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  oe_off_rst_a: assert property (!all_rel |-> clk_out_oe == 4'h0)
    else $error("clock enables on during pin reset");
  pins_off_rst_a: assert property (!all_rel |=> alarm_pin_oe == 4'h0 && !irq)
    else $error("pins active after pin reset");
  pins_hold_sync_a: assert property ($rose(all_rel) |-> (alarm_pin_oe == 4'h0 && !irq) [*3])
    else $error("release not synchronised");
  clk_cfg_wait_a: assert property ($rose(all_rel) |-> clk_out_oe == 4'h0 until s_axi_bvalid)
    else $error("clock enabled before configuration");
  irq_cause_a: assert property ($rose(irq) |-> $past(loss_of_signal) != 4'h0 || s_axi_bvalid)
    else $error("interrupt without cause");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready && all_rel |=> s_axi_rvalid || !all_rel)
    else $error("read answer late");
  cover property ($rose(all_rel));
  cover property ($rose(irq));
  cover property (alarm_pin_oe != 4'h0);
endmodule
bind pra_top pra_chk #(.SOFT_RST_CYC(SOFT_RST_CYC)) pra_chk_i (.aclk, .aresetn,
  .ext_reset_n_ch_a, .ext_reset_n_ch_b, .ext_reset_n_ch_c, .ext_reset_n_ch_d,
  .loss_of_signal, .clk_out_oe, .alarm_pin_oe, .irq, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);
`default_nettype wire

/* tb/pra_host.sv */
// Host model that drives the reset pins and reference loss lines.
`timescale 1ns/100ps
`default_nettype none
module pra_host (
  // Clock.
  input wire logic        aclk,
  // Reset pins toward the device.
  output wire logic       ext_reset_n_ch_a,
  output wire logic       ext_reset_n_ch_b,
  output wire logic       ext_reset_n_ch_c,
  output wire logic       ext_reset_n_ch_d,
  // Reference loss lines.
  output logic [3:0]      loss_of_signal
);
  // Pins rest high, as the weak pull-up leaves them.
  logic [3:0] rst_n_q = 4'hf;
  assign ext_reset_n_ch_a = rst_n_q[0];
  assign ext_reset_n_ch_b = rst_n_q[1];
  assign ext_reset_n_ch_c = rst_n_q[2];
  assign ext_reset_n_ch_d = rst_n_q[3];
  initial begin
    loss_of_signal = 4'h0;
  end
  task automatic drive_reset(input logic [3:0] v);
    rst_n_q <= v;
  endtask
  // Drive the loss lines.
  task automatic drive_loss(input logic [3:0] v);
    loss_of_signal <= v;
  endtask
  task automatic quiet_wait(input int n);
    repeat (n) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the reset and alarm pin block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pra_pkg::*;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
  // Clock, reset and counters.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  int   mismatches = 0;
  int   comparisons = 0;
  // Bus master side.
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  // Device outputs and host lines.
  wire logic   ext_reset_n_ch_a, ext_reset_n_ch_b, ext_reset_n_ch_c, ext_reset_n_ch_d;
  wire logic [3:0] loss_of_signal, clk_out_oe, alarm_pin_o, alarm_pin_oe;
  wire logic   irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  pra_host pra_host_i (.aclk, .ext_reset_n_ch_a, .ext_reset_n_ch_b,
    .ext_reset_n_ch_c, .ext_reset_n_ch_d, .loss_of_signal);
  pra_top #(.SOFT_RST_CYC(21'h14)) pra_top_i (.aclk, .aresetn, .ext_reset_n_ch_a,
    .ext_reset_n_ch_b, .ext_reset_n_ch_c, .ext_reset_n_ch_d, .loss_of_signal,
    .clk_out_oe, .alarm_pin_o, .alarm_pin_oe, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 200 MHz clock.
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // One write, address and data offered together; a late bready makes the answer stand.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf, input logic late = 1'b0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    // With a late ready the response is taken one edge after it is seen.
    if (late) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    `CHK("write resp", RESP_OK, s_axi_bresp)
    // Let one edge pass so the next call never re-raises ready in this step.
    @(posedge aclk);
  endtask
  // One read; ready comes late unless asked early, so both answer paths are seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    input logic early = 1'b0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= early;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    // A late ready holds the answer for one more edge.
    if (!early) begin
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Let one edge pass so the next call never re-raises ready in this step.
    @(posedge aclk);
  endtask
  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFF_CTRL, d, r); `CHK("ctrl", 32'h0, d)
    rd(OFF_PIN, d, r); `CHK("pin cfg", 32'h0000ff00, d)
    rd(OFF_MASK, d, r); `CHK("mask", 32'h0, d)
    rd(OFF_LIVE, d, r); `CHK("live", 32'h00000100, d)
    `CHK("clk oe", 4'h0, clk_out_oe)
    `CHK("pin oe", 4'h0, alarm_pin_oe)
    rd(8'h14, d, r); `CHK("unmapped", RESP_ERR, r)
  endtask
  task automatic t_ext_reset();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CTRL, 32'hf0); tick(2); `CHK("clk oe run", 4'hf, clk_out_oe)
    wr(OFF_PIN, 32'h0f); tick(2); `CHK("pin oe irq", 4'hf, alarm_pin_oe)
    pra_host_i.drive_reset(4'hd); tick(1); `CHK("clk oe rst", 4'h0, clk_out_oe)
    tick(2); `CHK("pin oe rst", 4'h0, alarm_pin_oe)
    pra_host_i.drive_reset(4'hf); tick(4);
    rd(OFF_CTRL, d, r); `CHK("ctrl after", 32'h0, d)
    rd(OFF_PIN, d, r); `CHK("pin after", 32'h0000ff00, d)
    `CHK("clk oe after", 4'h0, clk_out_oe)
  endtask
  task automatic t_alarm();
    wr(OFF_PIN, 32'hf0f0); pra_host_i.drive_loss(4'h5); tick(3);
    `CHK("alarm oe", 4'hf, alarm_pin_oe)
    `CHK("alarm high", 4'h5, alarm_pin_o)
    wr(OFF_PIN, 32'h00f0); tick(2); `CHK("alarm low", 4'ha, alarm_pin_o)
    wr(OFF_PIN, 32'h0); tick(2); `CHK("no function", 4'h0, alarm_pin_oe)
    pra_host_i.drive_loss(4'h0);
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_STAT, 32'hf); wr(OFF_MASK, 32'h1); wr(OFF_PIN, 32'h0f01); tick(2);
    `CHK("irq idle", 1'b0, irq)
    `CHK("irq pin oe", 4'h1, alarm_pin_oe)
    pra_host_i.drive_loss(4'h1); tick(3);
    `CHK("irq set", 1'b1, irq)
    `CHK("pin act hi", 4'h1, alarm_pin_o)
    wr(OFF_PIN, 32'h0e01); tick(2); `CHK("pin act lo", 4'h0, alarm_pin_o)
    wr(OFF_MASK, 32'h0); tick(2); `CHK("irq masked", 1'b0, irq)
    `CHK("pin masked", 4'h1, alarm_pin_o)
    rd(OFF_STAT, d, r); `CHK("stat set", 32'h1, d)
    wr(OFF_STAT, 32'h1); rd(OFF_STAT, d, r); `CHK("stat clear", 32'h0, d)
    pra_host_i.drive_loss(4'h0);
  endtask
  // Bus reset in mid-run, then a write under partial byte strobes.
  task automatic t_bus_reset();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_MASK, 32'hf, 4'hf, 1'b1);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    // The release synchroniser holds the block two more edges.
    tick(3);
    rd(OFF_MASK, d, r, 1'b1); `CHK("mask bus rst", 32'h0, d)
    wr(OFF_PIN, 32'h0f0f, 4'h1);
    rd(OFF_PIN, d, r); `CHK("pin strobe", 32'h0000ff0f, d)
    `CHK("pin oe strobe", 4'hf, alarm_pin_oe)
    wr(OFF_PIN, 32'h0);
  endtask
  task automatic t_soft();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CTRL, 32'hf1);
    `CHK("clk oe soft", 4'h0, clk_out_oe)
    pra_host_i.quiet_wait(30);
    rd(OFF_CTRL, d, r); `CHK("ctrl soft", 32'h0, d)
    rd(OFF_LIVE, d, r); `CHK("live soft", 32'h00000100, d)
    rd(OFF_PIN, d, r); `CHK("pin soft", 32'h0000ff00, d)
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // The release synchroniser holds the block two edges past the bus reset.
    repeat (3) @(posedge aclk);
    t_defaults();
    t_ext_reset();
    t_alarm();
    t_irq();
    t_bus_reset();
    t_soft();
    report_and_stop();
  end
  // Watchdog for a hang.
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
